// ==== ssc_pkg.sv ====
// shared constants and types for the supply-section serial control block
package ssc_pkg;
   // ----------------------------------------------------------------
   // system register layout
   // ----------------------------------------------------------------
   localparam int        SSC_BIT_PULSED_LIMIT = 7;
   localparam int        SSC_BIT_TX_OUTPUT    = 6;
   localparam int        SSC_BIT_TONE_FORCE   = 5;
   localparam int        SSC_BIT_LINE_LOSS    = 4;
   localparam int        SSC_BIT_HIGH_VOLT    = 3;
   localparam int        SSC_BIT_POWER_EN     = 2;
   localparam int        SSC_BIT_OVER_TEMP    = 1;
   localparam int        SSC_BIT_OVERLOAD     = 0;
   localparam logic [7:0] SSC_REG_RESET       = 8'h00;
   localparam logic [5:0] SSC_CTRL_RESET      = 6'h00;

   // ----------------------------------------------------------------
   // bus addressing
   // ----------------------------------------------------------------
   localparam logic [6:0] SSC_ADDR_BASE       = 7'h08;
   localparam logic       SSC_DIR_READ        = 1'b1;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam longint    SSC_CLK_HZ           = 25_000_000;
   localparam longint    SSC_T_OFF_MS         = 900;
   localparam longint    SSC_T_ON_DIV         = 10;
   localparam int        SSC_T_OFF_CYC        = int'((SSC_T_OFF_MS * SSC_CLK_HZ) / 1000);
   localparam int        SSC_T_ON_CYC         = int'((SSC_T_OFF_MS * SSC_CLK_HZ)
                                                     / (1000 * SSC_T_ON_DIV));
   localparam int        SSC_TMR_W            = 25;

   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SSC_IDLE, SSC_ADDR, SSC_ADDR_ACK, SSC_WR_DATA, SSC_WR_ACK, SSC_RD_DATA, SSC_RD_ACK
   } ssc_bus_st_t;

   typedef enum logic [1:0] {
      SSC_PL_NORMAL, SSC_PL_OFF, SSC_PL_RETRY
   } ssc_pl_st_t;

   // outputs toward the analog power section
   typedef struct packed {
      logic       power_on;
      logic [1:0] level;
      logic       tone_on;
      logic       transmit_supply_out;
      logic       receive_supply_out;
      logic       static_clamp;
   } ssc_pwr_t;

   typedef struct packed {
      logic                 scl_q;
      logic                 sda_q;
      ssc_bus_st_t          st;
      logic [2:0]           cnt;
      logic [7:0]           shift;
      logic                 rw;
      logic                 seen;
      logic                 mack;
      logic                 drv;
      logic [5:0]           ctrl;
      logic                 over_temp_flag;
      logic                 overload_flag;
      ssc_pl_st_t           pl_st;
      logic [SSC_TMR_W-1:0] tmr;
      ssc_pwr_t             pwr;
   } ssc_state_t;
endpackage : ssc_pkg

// ==== ssc_i2c_control.sv ====
// serial control slave, system register and protection sequencing of one supply section
`timescale 1ns/10ps

// Functional notes
// [RULE1] start is SDA falling with SCL high; stop is SDA rising with SCL high
// [RULE2] each byte is eight bits MSB first, then one acknowledge slot
// [RULE3] addressed device pulls SDA low through the ninth clock of each received byte
// [RULE4] no acknowledge while supply is under the lockout threshold
// [RULE5] master may stop after a missing acknowledge to abort
// [RULE6] master may ignore acknowledge and just clock one extra pulse
// [RULE7] transaction: start, address 10h write or 11h read, data byte, stop
// [RULE8] one data byte with acknowledge sits between address and stop
// [RULE9] register bits: limit mode, tx select, tone, line loss, voltage, enable, flags
// [RULE10] every register bit is zero after power-on
// [RULE11] write direction updates upper six bits; flag bits ignore writes
// [RULE12] line loss and voltage select choose one of four output levels
// [RULE13] tone follows key pin unless tone force bit keeps it on
// [RULE14] tx select clear enables receive output, set enables transmit output with tone
// [RULE15] limit mode bit zero is pulsed protection, one is static clamp
// [RULE16] read direction shifts register out MSB first after address acknowledge
// [RULE17] master acknowledge requests another read byte; not-acknowledge ends read
// [RULE18] read returns upper six bits exactly as last written
// [RULE19] flags show over-temperature shutdown and triggered overload protection
// [RULE20] under lockout the bus is ignored and register held at zero
// [RULE21] slave address 0001000 with strap low; strap picks one of four
// [RULE22] host sets tx select only while a tone transmission runs
// [RULE23] power enable clear puts the section in standby whatever else is set
// [RULE24] pulsed mode: overload shuts output for off time, retries a tenth, flag clears
// [RULE25] static mode: overload flag follows the clamp condition
// [RULE26] SDA sampled on SCL rise; own drive changes only while SCL is low
module ssc_i2c_control #(
   parameter int T_OFF_CYC = ssc_pkg::SSC_T_OFF_CYC,
   parameter int T_ON_CYC  = ssc_pkg::SSC_T_ON_CYC
) (
   input  wire logic            clk_sys,
   input  wire logic            resetn,
   input  wire logic            undervoltage_lockout,
   input  wire logic [1:0]      addr_strap,
   input  wire logic            scl_in,
   input  wire logic            sda_in,
   output logic                 sda_out,
   output logic                 sda_oe_n,
   input  wire logic            tone_key_in,
   input  wire logic            over_temp_in,
   input  wire logic            overload_in,
   output ssc_pkg::ssc_pwr_t    pwr,
   output logic [7:0]           supply_control_status
);
   import ssc_pkg::*;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (T_OFF_CYC < 1 || T_ON_CYC < 1 || T_OFF_CYC >= (1 << SSC_TMR_W)
       || T_ON_CYC >= (1 << SSC_TMR_W)) begin : g_bad_timing
      $error("protection times must fit the timer and be at least one cycle");
   end

   localparam logic [SSC_TMR_W-1:0] OFF_LAST = SSC_TMR_W'(T_OFF_CYC - 1);
   localparam logic [SSC_TMR_W-1:0] ON_LAST  = SSC_TMR_W'(T_ON_CYC - 1);

   ssc_state_t s;
   ssc_state_t next_s;
   logic [6:0] my_addr;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_c;
   logic       stop_c;
   logic [7:0] in_byte;
   logic [7:0] reg_view;

   // ----------------------------------------------------------------
   // strap capture
   // ----------------------------------------------------------------
   // strap pins are sampled by the first clock after reset; the reset itself only clears the copy to zero
   logic [1:0] strap;
   logic       strap_done;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         strap      <= 2'h0;
         strap_done <= 1'b0;
      end else if (!strap_done) begin
         strap      <= addr_strap;
         strap_done <= 1'b1;
      end
   end
   assign my_addr = SSC_ADDR_BASE | {5'h00, strap}; // [RULE21]

   // ----------------------------------------------------------------
   // bus conditions
   // ----------------------------------------------------------------
   // pins are synchronous, so one stage of history is enough for edges
   assign scl_rise = scl_in && !s.scl_q;
   assign scl_fall = !scl_in && s.scl_q;
   assign start_c  = scl_in && s.scl_q && s.sda_q && !sda_in; // [RULE1]
   assign stop_c   = scl_in && s.scl_q && !s.sda_q && sda_in; // [RULE1]
   assign in_byte  = {s.shift[6:0], sda_in};                  // [RULE2]
   assign reg_view = {s.ctrl, s.over_temp_flag, s.overload_flag};                  // [RULE9] [RULE18]

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s       = s;
      next_s.scl_q = scl_in;
      next_s.sda_q = sda_in;

      // serial protocol engine
      if (start_c) begin
         next_s.st  = SSC_ADDR;
         next_s.cnt = 3'h0;
         next_s.drv = 1'b0;
      end else if (stop_c) begin
         next_s.st  = SSC_IDLE;
         next_s.drv = 1'b0;
      end else begin
         unique case (s.st)
            SSC_IDLE: begin
               next_s.drv = 1'b0;
            end
            SSC_ADDR, SSC_WR_DATA: begin
               if (scl_rise) begin
                  next_s.shift = in_byte;                   // [RULE26]
                  next_s.cnt   = s.cnt + 3'h1;
                  if (s.cnt == 3'h7) begin
                     if (s.st == SSC_WR_DATA) begin
                        next_s.ctrl = in_byte[7:2];         // [RULE11]
                        next_s.st   = SSC_WR_ACK;           // [RULE8]
                     end else if (in_byte[7:1] == my_addr) begin
                        next_s.rw = in_byte[0];             // [RULE7]
                        next_s.st = SSC_ADDR_ACK;
                     end else begin
                        next_s.st = SSC_IDLE;
                     end
                  end
               end
            end
            SSC_ADDR_ACK, SSC_WR_ACK: begin
               if (scl_fall) begin
                  if (!s.drv) begin
                     next_s.drv = 1'b1;                     // [RULE3]
                  end else begin
                     next_s.cnt = 3'h0;
                     if (s.st == SSC_ADDR_ACK && s.rw == SSC_DIR_READ) begin
                        next_s.shift = reg_view;            // [RULE16]
                        next_s.drv   = !reg_view[7];
                        next_s.st    = SSC_RD_DATA;
                     end else begin
                        next_s.drv = 1'b0;                  // [RULE26]
                        next_s.st  = SSC_WR_DATA;
                     end
                  end
               end
            end
            SSC_RD_DATA: begin
               if (scl_rise) begin
                  next_s.cnt = s.cnt + 3'h1;
                  if (s.cnt == 3'h7) begin
                     next_s.st   = SSC_RD_ACK;
                     next_s.seen = 1'b0;
                  end
               end else if (scl_fall) begin
                  next_s.shift = {s.shift[6:0], 1'b0};      // [RULE16]
                  next_s.drv   = !s.shift[6];
               end
            end
            SSC_RD_ACK: begin
               if (scl_rise) begin
                  next_s.mack = !sda_in;
                  next_s.seen = 1'b1;
               end else if (scl_fall) begin
                  if (!s.seen) begin
                     next_s.drv = 1'b0;                     // [RULE26]
                  end else if (s.mack) begin
                     next_s.shift = reg_view;               // [RULE17]
                     next_s.drv   = !reg_view[7];
                     next_s.cnt   = 3'h0;
                     next_s.st    = SSC_RD_DATA;
                  end else begin
                     next_s.st = SSC_IDLE;                  // [RULE17]
                  end
               end
            end
            default: begin
               next_s.st  = SSC_IDLE;
               next_s.drv = 1'b0;
            end
         endcase
      end

      // diagnostic flags
      next_s.over_temp_flag = over_temp_in;                            // [RULE19]
      if (s.ctrl[SSC_BIT_PULSED_LIMIT - 2]) begin
         next_s.pl_st = SSC_PL_NORMAL;
         next_s.tmr   = '0;
         next_s.overload_flag   = overload_in;                        // [RULE25]
      end else begin
         // pulsed protection sequencer; the timer keeps dissipation low in a short
         unique case (s.pl_st)
            SSC_PL_NORMAL: begin
               next_s.tmr = '0;
               if (overload_in) begin
                  next_s.pl_st = SSC_PL_OFF;                // [RULE24]
                  next_s.overload_flag   = 1'b1;
               end
            end
            SSC_PL_OFF: begin
               next_s.overload_flag = 1'b1;
               next_s.tmr = s.tmr + SSC_TMR_W'(1);
               if (s.tmr == OFF_LAST) begin
                  next_s.tmr   = '0;
                  next_s.pl_st = SSC_PL_RETRY;
               end
            end
            SSC_PL_RETRY: begin
               next_s.tmr = s.tmr + SSC_TMR_W'(1);
               if (overload_in) begin
                  // retry ended early would hide a hard short, so restart the off time
                  next_s.tmr   = '0;
                  next_s.pl_st = SSC_PL_OFF;                // [RULE24]
               end else if (s.tmr == ON_LAST) begin
                  next_s.tmr   = '0;
                  next_s.overload_flag   = 1'b0;                      // [RULE24]
                  next_s.pl_st = SSC_PL_NORMAL;
               end
            end
            default: begin
               next_s.pl_st = SSC_PL_NORMAL;
               next_s.tmr   = '0;
            end
         endcase
      end

      // power section controls, registered
      next_s.pwr.power_on = s.ctrl[SSC_BIT_POWER_EN - 2] && !s.over_temp_flag
                            && (s.pl_st != SSC_PL_OFF);      // [RULE23]
      next_s.pwr.level    = {s.ctrl[SSC_BIT_LINE_LOSS - 2],
                             s.ctrl[SSC_BIT_HIGH_VOLT - 2]}; // [RULE12]
      next_s.pwr.tone_on  = s.ctrl[SSC_BIT_POWER_EN - 2]
                            && (s.ctrl[SSC_BIT_TONE_FORCE - 2] || tone_key_in); // [RULE13]
      next_s.pwr.transmit_supply_out = s.ctrl[SSC_BIT_POWER_EN - 2]
                                       && s.ctrl[SSC_BIT_TX_OUTPUT - 2];  // [RULE14]
      next_s.pwr.receive_supply_out  = s.ctrl[SSC_BIT_POWER_EN - 2]
                                       && !s.ctrl[SSC_BIT_TX_OUTPUT - 2]; // [RULE14]
      next_s.pwr.static_clamp = s.ctrl[SSC_BIT_PULSED_LIMIT - 2];        // [RULE15]

      // lockout silences the bus and clears the register
      if (undervoltage_lockout) begin
         next_s.st   = SSC_IDLE;                            // [RULE20]
         next_s.drv  = 1'b0;                                // [RULE4]
         next_s.ctrl = SSC_CTRL_RESET;
         next_s.overload_flag  = 1'b0;
         next_s.over_temp_flag  = 1'b0;
         next_s.pl_st = SSC_PL_NORMAL;
         next_s.tmr   = '0;
         next_s.pwr   = '0;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s       <= '0;                                     // [RULE10]
         s.scl_q <= 1'b1;
         s.sda_q <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // open-drain: only ever pull low
   assign sda_out               = 1'b0;
   assign sda_oe_n              = !s.drv;
   assign pwr                   = s.pwr;
   assign supply_control_status = reg_view;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   AST_START_TO_ADDR: assert property (start_c && !undervoltage_lockout |=> s.st == SSC_ADDR) // [RULE1]
      else $error("start not recognised");
   AST_STOP_RELEASE: assert property (stop_c |=> sda_oe_n && s.st == SSC_IDLE) // [RULE1]
      else $error("stop did not release the bus");
   AST_ACK_HELD: assert property ((s.st == SSC_ADDR_ACK || s.st == SSC_WR_ACK) && s.drv
                                  && !scl_fall && !start_c && !stop_c
                                  && !undervoltage_lockout |=> !sda_oe_n) // [RULE3]
      else $error("acknowledge released early");
   AST_LOCKOUT_SILENT: assert property (undervoltage_lockout |=> sda_oe_n
                                        && supply_control_status == SSC_REG_RESET) // [RULE4]
      else $error("bus active or register set during lockout");
   AST_WRITE_UPPER: assert property (s.st == SSC_WR_DATA && scl_rise && s.cnt == 3'h7
                                     && !start_c && !stop_c && !undervoltage_lockout
                                     |=> s.ctrl == $past(in_byte[7:2])) // [RULE11]
      else $error("write did not land in control bits");
   AST_DRIVE_SCL_LOW: assert property ($rose(s.drv) |-> !s.scl_q) // [RULE26]
      else $error("data drive changed with clock high");
   AST_OTF_FOLLOWS: assert property (over_temp_in && !undervoltage_lockout
                                     |=> supply_control_status[SSC_BIT_OVER_TEMP]) // [RULE19]
      else $error("over-temperature flag missing");
   AST_STATIC_FLAG: assert property (s.ctrl[SSC_BIT_PULSED_LIMIT - 2] && overload_in
                                     && !undervoltage_lockout |=> s.overload_flag) // [RULE25]
      else $error("static overload flag missing");
   AST_STANDBY: assert property (!s.ctrl[SSC_BIT_POWER_EN - 2] |=> !pwr.power_on
                                 && !pwr.tone_on) // [RULE23]
      else $error("power on while disabled");
   AST_PULSED_OFF: assert property (s.pl_st == SSC_PL_OFF && !undervoltage_lockout
                                    && !s.ctrl[SSC_BIT_PULSED_LIMIT - 2]
                                    |=> s.overload_flag && !pwr.power_on) // [RULE24]
      else $error("pulsed off phase not enforced");

   COV_WRITE: cover property (s.st == SSC_WR_ACK ##[1:1000] stop_c);
   COV_READ:  cover property (s.st == SSC_RD_ACK && scl_fall && s.seen && !s.mack);
   COV_PULSE: cover property (s.pl_st == SSC_PL_RETRY ##1 s.pl_st == SSC_PL_NORMAL);
endmodule : ssc_i2c_control

// ==== ssc_host_model.sv ====
// bus master model that drives the serial control lines of one supply section
`timescale 1ns/10ps
module ssc_host_model #(
   parameter int HALF = 4
) (
   input  wire logic       clk_sys,
   input  wire logic       sda_line,
   output logic            scl,
   output logic            sda_drv,
   output logic            res_valid,
   output logic [7:0]      res_data
);
   // ----------------------------------------------------------------
   // bit and byte level helpers
   // ----------------------------------------------------------------
   // bus idles released; the line then sits at its pull-up level
   initial begin
      scl       = 1'b1;
      sda_drv   = 1'b1;
      res_valid = 1'b0;
      res_data  = 8'h00;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wait_clk

   // hand one observed result to the bench for one cycle
   task automatic post(input logic [7:0] v);
      res_data  = v;
      res_valid = 1'b1;
      wait_clk(1);
      res_valid = 1'b0;
   endtask : post

   // data set up in the low phase, sampled in mid high phase
   task automatic clock_bit(input logic b, output logic s);
      sda_drv = b;
      wait_clk(HALF);
      scl = 1'b1;
      wait_clk(HALF / 2);
      s = sda_line;
      wait_clk(HALF / 2);
      scl = 1'b0;
      wait_clk(1); // hold data past the falling edge
   endtask : clock_bit

   task automatic start();
      sda_drv = 1'b1;
      scl     = 1'b1;
      wait_clk(HALF);
      sda_drv = 1'b0;
      wait_clk(HALF);
      scl = 1'b0;
      wait_clk(1);
   endtask : start

   task automatic stop();
      sda_drv = 1'b0;
      wait_clk(HALF);
      scl = 1'b1;
      wait_clk(HALF);
      sda_drv = 1'b1;
      wait_clk(HALF);
   endtask : stop

   // ack is only reported, never acted on: the next byte always follows
   task automatic send_byte(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(b[i], s);
      end
      clock_bit(1'b1, s);
      post({7'h00, s});
   endtask : send_byte

   task automatic recv_byte(input logic more);
      logic [7:0] v;
      logic       s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(1'b1, v[i]);
      end
      post(v);
      clock_bit(~more, s);
   endtask : recv_byte

   // ----------------------------------------------------------------
   // whole transactions
   // ----------------------------------------------------------------
   task automatic write_txn(input logic [6:0] a, input logic [7:0] d);
      start();
      send_byte({a, 1'b0});
      send_byte(d);
      stop();
   endtask : write_txn

   task automatic read_txn(input logic [6:0] a, input int n);
      start();
      send_byte({a, 1'b1});
      for (int k = 0; k < n; k++) begin
         recv_byte(k < n - 1);
      end
      stop();
   endtask : read_txn
endmodule : ssc_host_model

// ==== tb_sat_supply_i2c_control.sv ====
// self-checking bench for the supply-section serial control block
`timescale 1ns/10ps
module tb_sat_supply_i2c_control;
   import ssc_pkg::*;
   localparam int T_OFF = 20;
   localparam int T_ON  = 4;
   logic       clk_sys, resetn, undervoltage_lockout, tone_key_in, over_temp_in, overload_in;
   logic [1:0] addr_strap;
   logic       scl, sda_drv, sda_out, sda_oe_n, res_valid;
   logic [7:0] res_data, supply_control_status;
   logic [6:0] dev_addr;
   logic [31:0] rng;
   wire        sda_line;
   ssc_pwr_t   pwr;
   int         n_errors = 0;
   int         cmp_count = 0;
   logic [7:0] exp_q[$];

   // open-drain wire: either party can pull low, pull-up otherwise
   assign sda_line = sda_drv & (sda_oe_n | sda_out);

   ssc_i2c_control #(
      .T_OFF_CYC (T_OFF),
      .T_ON_CYC  (T_ON)
   ) dut_u (
      .clk_sys               (clk_sys),
      .resetn                (resetn),
      .undervoltage_lockout  (undervoltage_lockout),
      .addr_strap            (addr_strap),
      .scl_in                (scl),
      .sda_in                (sda_line),
      .sda_out               (sda_out),
      .sda_oe_n              (sda_oe_n),
      .tone_key_in           (tone_key_in),
      .over_temp_in          (over_temp_in),
      .overload_in           (overload_in),
      .pwr                   (pwr),
      .supply_control_status (supply_control_status)
   );

   ssc_host_model host_u (
      .clk_sys   (clk_sys),
      .sda_line  (sda_line),
      .scl       (scl),
      .sda_drv   (sda_drv),
      .res_valid (res_valid),
      .res_data  (res_data)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // expected power outputs for a written byte with no overload pending
   function automatic logic [7:0] exp_pwr(input logic [7:0] d, input logic ot, input logic key);
      logic en;
      en = d[SSC_BIT_POWER_EN];
      return {1'b0, en & ~ot, d[4:3], en & (d[5] | key), en & d[6], en & ~d[6], d[7]};
   endfunction : exp_pwr

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wait_clk

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   // ----------------------------------------------------------------
   // result watcher: every ack bit and read byte against the oldest note
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (res_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("unexpected result at %0t: nothing was expected", $time);
         end else begin
            check(res_data, exp_q.pop_front());
         end
      end
   end

   // a hung handshake must not stall the run forever
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_errors++;
      $display("unexpected stall at %0t: run did not finish", $time);
      wrap_up();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin : main
      logic [7:0] d;
      logic [7:0] st;
      resetn               = 1'b0;
      undervoltage_lockout = 1'b0;
      overload_in          = 1'b0;
      rng                  = xs(32'h0d9fa669);
      tone_key_in          = rng[8];
      over_temp_in         = rng[9];
      addr_strap           = rng[1:0];
      dev_addr             = SSC_ADDR_BASE | {5'h00, rng[1:0]};
      wait_clk(16);
      check(supply_control_status, SSC_REG_RESET);
      check({1'b0, pwr}, 8'h00);
      resetn = 1'b1;
      wait_clk(4);
      // every level, tone and output code; flag bits written random
      for (int i = 0; i < 8; i++) begin
         rng = xs(rng);
         d = {i[2], i[2:1], i[1:0], (i != 5), rng[1:0]};
         tone_key_in  = rng[8] | i[2];
         over_temp_in = (i == 6);
         st = {d[7:2], over_temp_in, 1'b0};
         exp_q.push_back(8'h00);
         exp_q.push_back(8'h00);
         host_u.write_txn(dev_addr, d);
         wait_clk(2);
         check(supply_control_status, st);
         check({1'b0, pwr}, exp_pwr(d, over_temp_in, tone_key_in));
         exp_q.push_back(8'h00);
         exp_q.push_back(st);
         exp_q.push_back(st);
         host_u.read_txn(dev_addr, 2);
      end
      // foreign address: no ack, register untouched
      wait_clk(2);
      st = {d[7:2], 2'b00};
      exp_q.push_back(8'h01);
      exp_q.push_back(8'h01);
      host_u.write_txn(dev_addr ^ 7'h04, 8'h00);
      check(supply_control_status, st);
      // pulsed limit: off period, retry, then flag clears
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h00);
      host_u.write_txn(dev_addr, 8'h04);
      // one-cycle overload pulse
      overload_in = ~overload_in;
      wait_clk(1);
      overload_in = ~overload_in;
      wait_clk(2);
      check(supply_control_status, 8'h05);
      check({7'h00, pwr.power_on}, 8'h00);
      wait_clk(17);
      check({7'h00, pwr.power_on}, 8'h00);
      wait_clk(15);
      check(supply_control_status, 8'h04);
      check({7'h00, pwr.power_on}, 8'h01);
      // static clamp: flag follows the overload level, output stays on
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h00);
      host_u.write_txn(dev_addr, 8'h84);
      overload_in = ~overload_in;
      wait_clk(3);
      check(supply_control_status, 8'h85);
      check({7'h00, pwr.power_on}, 8'h01);
      overload_in = ~overload_in;
      wait_clk(3);
      check(supply_control_status, 8'h84);
      // lockout: register cleared, bus ignored, then operative again
      undervoltage_lockout = ~undervoltage_lockout;
      rng                  = xs(rng);
      over_temp_in         = rng[0]; // pins under lockout must not reach the register
      tone_key_in          = rng[1];
      wait_clk(3);
      check(supply_control_status, 8'h00);
      exp_q.push_back(8'h01);
      exp_q.push_back(8'h01);
      host_u.write_txn(dev_addr, 8'hfc);
      check(supply_control_status, 8'h00);
      check({1'b0, pwr}, 8'h00);
      undervoltage_lockout = ~undervoltage_lockout;
      over_temp_in         = 1'b0;
      wait_clk(4);
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h00);
      host_u.write_txn(dev_addr, 8'hfc);
      wait_clk(2);
      check(supply_control_status, 8'hfc);
      check(exp_q.size() == 0 ? 8'h00 : 8'hff, 8'h00);
      wrap_up();
   end
endmodule : tb_sat_supply_i2c_control
